// ===== dv/switch_address_lookup_forwarding_tb.sv
// Self-checking bench for the look-up and forwarding engine
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module switch_address_lookup_forwarding_tb;
    import swl_pkg::*;
    localparam swl_mac_t A = 48'h0000_0000_00A1, B = 48'h0000_0000_00B2;
    localparam swl_mac_t C = 48'h0000_0000_00C3, D = 48'h0000_0000_00D4;
    localparam swl_mac_t E = 48'h0000_0000_00E5, G = 48'h0000_0000_0067;
    localparam swl_mac_t H = 48'h0000_0000_0078, Z = 48'h0000_0000_00FF;
    localparam swl_mac_t M = 48'h0100_0000_0001;
    logic core_clk, rst_n, frm_valid, frm_ready, frm_err, frm_pause, frm_tagged;
    logic static_hit, acl_hit, fwd_valid, fwd_ready, buf_rel_valid, drop_pulse, stall;
    logic [7:0] glb_cfg;
    logic [10:0] max_len, frm_len;
    logic [3:0] fwd_nbuf, buf_rel_cnt;
    logic [9:0] buf_free;
    swl_port_t frm_port, fwd_src;
    swl_mac_t frm_sa, frm_da;
    swl_pmask_t static_ports, vlan_member, stp_fwd, auth_ok, mirror_ports, acl_ports, fwd_ports;
    int n_fail, cmp_count;

    // Short aging tick keeps the run small; must exceed one table scan
    swl_engine #(.AGE_TICK_CYC(32'd2000)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .glb_cfg(glb_cfg), .max_len(max_len), .frm_valid(frm_valid), .frm_ready(frm_ready),
        .frm_port(frm_port), .frm_sa(frm_sa), .frm_da(frm_da), .frm_len(frm_len),
        .frm_err(frm_err), .frm_pause(frm_pause), .frm_tagged(frm_tagged),
        .static_hit(static_hit), .static_ports(static_ports), .vlan_member(vlan_member),
        .stp_fwd(stp_fwd), .auth_ok(auth_ok), .mirror_ports(mirror_ports), .acl_hit(acl_hit),
        .acl_ports(acl_ports), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready),
        .fwd_ports(fwd_ports), .fwd_src(fwd_src), .fwd_nbuf(fwd_nbuf),
        .buf_rel_valid(buf_rel_valid), .buf_rel_cnt(buf_rel_cnt), .buf_free(buf_free),
        .drop_pulse(drop_pulse));
    swl_mac_model i_mac (.core_clk(core_clk), .rst_n(rst_n), .stall(stall),
        .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd_ports(fwd_ports), .fwd_src(fwd_src),
        .fwd_nbuf(fwd_nbuf), .buf_rel_valid(buf_rel_valid), .buf_rel_cnt(buf_rel_cnt));

    // Free-running 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic bound(input int i, input int lim);
        if (i >= lim) begin
            n_fail++;
            $display("ERROR handshake timed out");
            wrap_up();
        end
    endtask

    // Offer one frame; mode 0 take only, 1 wait for resolve, 2 also judge
    task automatic frame(input swl_port_t p, input swl_mac_t sa, da, input logic [10:0] len,
                         input swl_pmask_t exp, input int mode);
        int i;
        logic hit;
        logic [10:0] up;
        logic [11:0] w;
        up = len + 11'h07F;
        hit = 1'b0;
        @(negedge core_clk);
        frm_port = p;
        frm_sa = sa;
        frm_da = da;
        frm_len = len;
        frm_valid = 1'b1;
        i = 0;
        while (frm_ready !== 1'b1 && i < 3000) begin
            cyc(1);
            i++;
        end
        bound(i, 3000);
        cyc(1);
        frm_valid = 1'b0;
        if (mode > 0) begin
            i = 0;
            while (frm_ready !== 1'b1 && i < 1200) begin
                cyc(1);
                i++;
                hit = hit | (drop_pulse === 1'b1);
            end
            bound(i, 1200);
            cyc(2);
        end
        if (mode == 2 && exp == 5'h00) begin
            `CHK("drop", 1'b1, hit)
            `CHK("pushed", 0, i_mac.got.size())
        end else if (mode == 2) begin
            `CHK("pushed", 1, i_mac.got.size())
            if (i_mac.got.size() > 0) begin
                w = i_mac.got.pop_front();
                `CHK("fwd", {exp, p, up[10:7]}, w)
            end
        end
    endtask

    task automatic t_learn();
        frame(3'h0, A, B, 11'h040, 5'h1E, 2);
        frame(3'h1, B, A, 11'h081, 5'h01, 2);
        frame(3'h0, C, A, 11'h040, 5'h00, 2);
        frame(3'h2, A, B, 11'h040, 5'h02, 2);
        frame(3'h3, D, A, 11'h040, 5'h04, 2);
        // Group address known on the ingress port still floods, never local
        frame(3'h1, M, Z, 11'h040, 5'h1D, 2);
        frame(3'h1, B, M, 11'h040, 5'h1D, 2);
    endtask

    task automatic t_bad();
        frm_err = 1'b1;
        frame(3'h4, E, B, 11'h040, 5'h00, 2);
        frm_err = 1'b0;
        frame(3'h4, E, B, 11'h03F, 5'h00, 2);
        frame(3'h4, E, B, 11'h5EF, 5'h00, 2);
        // Configured limit above the cap is clamped to 1536
        max_len = 11'h7FF;
        frame(3'h4, E, B, 11'h601, 5'h00, 2);
        max_len = 11'h5EE;
        frame(3'h0, C, E, 11'h040, 5'h1E, 2);
        frm_tagged = 1'b1;
        frame(3'h4, E, B, 11'h5F2, 5'h02, 2);
        frm_tagged = 1'b0;
        frm_pause = 1'b1;
        frame(3'h3, D, B, 11'h040, 5'h00, 2);
        frm_pause = 1'b0;
    endtask

    task automatic t_policy();
        stp_fwd = 5'h1B;
        auth_ok = 5'h17;
        mirror_ports = 5'h08;
        frame(3'h0, C, Z, 11'h040, 5'h1A, 2);
        acl_hit = 1'b1;
        acl_ports = 5'h04;
        frame(3'h0, C, Z, 11'h040, 5'h04, 2);
        acl_hit = 1'b0;
        mirror_ports = 5'h00;
        stp_fwd = 5'h1F;
        auth_ok = 5'h1F;
        static_hit = 1'b1;
        static_ports = 5'h10;
        frame(3'h0, C, E, 11'h040, 5'h10, 2);
        static_hit = 1'b0;
        vlan_member = 5'h0B;
        frame(3'h0, C, Z, 11'h040, 5'h0A, 2);
        vlan_member = 5'h1F;
        stp_fwd = 5'h00;
        frame(3'h0, C, Z, 11'h040, 5'h00, 2);
        stp_fwd = 5'h1F;
    endtask

    // FIFO filled with the far side stalled, then drained to empty
    task automatic t_fill();
        logic [11:0] w;
        stall = 1'b1;
        frame(3'h0, C, Z, 11'h5EE, 5'h00, 1);
        repeat (15) frame(3'h0, C, Z, 11'h040, 5'h00, 1);
        `CHK("buf_free", 10'h1E5, buf_free)
        frame(3'h0, C, Z, 11'h040, 5'h00, 0);
        cyc(1200);
        `CHK("frm_ready", 1'b0, frm_ready)
        `CHK("fwd_valid", 1'b1, fwd_valid)
        stall = 1'b0;
        cyc(200);
        `CHK("drained", 17, i_mac.got.size())
        for (int k = 0; k < 17 && i_mac.got.size() > 0; k++) begin
            w = i_mac.got.pop_front();
            `CHK("fwd", {5'h1E, 3'h0, (k == 0) ? 4'hC : 4'h1}, w)
        end
        `CHK("buf_free", 10'h200, buf_free)
    endtask

    // Entry survives with aging off, expires with it on unless refreshed
    task automatic t_age();
        frame(3'h1, G, Z, 11'h040, 5'h1D, 2);
        cyc(12000);
        frame(3'h0, C, G, 11'h040, 5'h02, 2);
        glb_cfg = 8'h04;
        frame(3'h4, H, Z, 11'h040, 5'h0F, 2);
        repeat (5) begin
            cyc(2000);
            frame(3'h4, H, Z, 11'h040, 5'h0F, 2);
        end
        frame(3'h0, C, G, 11'h040, 5'h1E, 2);
        frame(3'h0, C, H, 11'h040, 5'h10, 2);
    endtask

    // Main sequence: all inputs set at time zero, reset held six cycles
    initial begin
        n_fail = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        stall = 1'b0;
        glb_cfg = 8'h00;
        max_len = 11'h5EE;
        {frm_valid, frm_err, frm_pause, frm_tagged, static_hit, acl_hit} = 6'h00;
        frm_port = 3'h0;
        frm_sa = 48'h0;
        frm_da = 48'h0;
        frm_len = 11'h040;
        {static_ports, mirror_ports, acl_ports} = 15'h0000;
        {vlan_member, stp_fwd, auth_ok} = 15'h7FFF;
        cyc(6);
        `CHK("buf_free", 10'h200, buf_free)
        `CHK("fwd_valid", 1'b0, fwd_valid)
        rst_n = 1'b1;
        t_learn();
        t_bad();
        t_policy();
        t_fill();
        t_age();
        wrap_up();
    end
endmodule

// ===== dv/swl_mac_model.sv
// Far-side MAC model: drains forward descriptors and returns their buffers
`timescale 1ns/1ps
module swl_mac_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic fwd_valid,
    output logic fwd_ready,
    input wire swl_pkg::swl_pmask_t fwd_ports,
    input wire swl_pkg::swl_port_t fwd_src,
    input wire logic [3:0] fwd_nbuf,
    output logic buf_rel_valid,
    output logic [3:0] buf_rel_cnt
);
    import swl_pkg::*;
    logic [11:0] got[$];
    // Take words when not stalled; buffers go back the cycle after transmit
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_ready <= 1'b0;
            buf_rel_valid <= 1'b0;
            buf_rel_cnt <= 4'h0;
        end else begin
            fwd_ready <= !stall;
            buf_rel_valid <= fwd_valid && fwd_ready;
            // Idle count toggles so a stale value is never mistaken for data
            buf_rel_cnt <= (fwd_valid && fwd_ready) ? fwd_nbuf : ~buf_rel_cnt;
            if (fwd_valid && fwd_ready) begin
                got.push_back({fwd_ports, fwd_src, fwd_nbuf});
            end
        end
    end
endmodule

// ===== rtl/swl_engine.sv
// Address learning, aging and egress resolution for a five-port switch
`timescale 1ns/1ps
`include "swl_params.svh"
module swl_engine #(
    parameter logic [31:0] AGE_TICK_CYC = 32'(64'(`SWL_AGE_TICK_S) * 64'(`SWL_CLK_HZ))
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] glb_cfg,
    input wire logic [10:0] max_len,
    input wire logic frm_valid,
    output logic frm_ready,
    input wire swl_pkg::swl_port_t frm_port,
    input wire swl_pkg::swl_mac_t frm_sa,
    input wire swl_pkg::swl_mac_t frm_da,
    input wire logic [10:0] frm_len,
    input wire logic frm_err,
    input wire logic frm_pause,
    input wire logic frm_tagged,
    input wire logic static_hit,
    input wire swl_pkg::swl_pmask_t static_ports,
    input wire swl_pkg::swl_pmask_t vlan_member,
    input wire swl_pkg::swl_pmask_t stp_fwd,
    input wire swl_pkg::swl_pmask_t auth_ok,
    input wire swl_pkg::swl_pmask_t mirror_ports,
    input wire logic acl_hit,
    input wire swl_pkg::swl_pmask_t acl_ports,
    output logic fwd_valid,
    input wire logic fwd_ready,
    output swl_pkg::swl_pmask_t fwd_ports,
    output swl_pkg::swl_port_t fwd_src,
    output logic [3:0] fwd_nbuf,
    input wire logic buf_rel_valid,
    input wire logic [3:0] buf_rel_cnt,
    output logic [9:0] buf_free,
    output logic drop_pulse
);
    import swl_pkg::*;

    function automatic swl_pmask_t port_mask(input swl_port_t p);
        port_mask = 5'(5'h01 << p);
    endfunction

    function automatic logic [3:0] buf_need(input logic [10:0] len);
        buf_need = 4'((len + `SWL_BUF_ROUND) >> `SWL_BUF_SHIFT);
    endfunction

    // Entry store: any address can take any slot, no hashing
    logic tbl_vld_q [`SWL_TBL_ENTRIES];
    swl_mac_t tbl_mac_q [`SWL_TBL_ENTRIES];
    swl_port_t tbl_port_q [`SWL_TBL_ENTRIES];
    logic [2:0] tbl_stamp_q [`SWL_TBL_ENTRIES];

    swl_state_t st_q;
    swl_state_t st_d;
    logic [9:0] scan_idx_q;
    logic [9:0] scan_cnt_q;
    logic [31:0] tick_cnt_q;
    logic [2:0] now_q;
    swl_port_t port_q;
    swl_mac_t sa_q;
    swl_mac_t da_q;
    logic [10:0] len_q;
    logic err_q, pause_q, tagged_q, st_hit_q, acl_hit_q;
    swl_pmask_t st_ports_q, vlan_q, stp_q, auth_q, mir_q, acl_ports_q;
    logic sa_hit_q, da_hit_q, free_found_q;
    logic [9:0] sa_idx_q;
    logic [9:0] free_idx_q;
    swl_port_t sa_port_q;
    swl_port_t da_port_q;
    logic [9:0] buf_free_q;
    logic drop_q;

    // Background scanner: one entry per cycle, so every entry is seen
    // each 1024 cycles, far inside one aging tick
    wire aging_en = glb_cfg[`SWL_AGE_EN_BIT];
    wire tick = (tick_cnt_q == AGE_TICK_CYC - 32'd1);
    wire cur_vld = tbl_vld_q[scan_idx_q];
    wire [2:0] cur_age = now_q - tbl_stamp_q[scan_idx_q];
    wire expire = cur_vld && aging_en && (cur_age >= `SWL_AGE_LIMIT);
    wire live = cur_vld && !expire;
    wire sa_match = live && (tbl_mac_q[scan_idx_q] == sa_q);
    wire da_match = live && (tbl_mac_q[scan_idx_q] == da_q);
    wire scan_last = (scan_cnt_q == `SWL_LAST_IDX);

    // Frame qualification; the length limit grows for a tag
    wire [10:0] cap_len = (max_len > `SWL_MAX_LEN_CAP) ? `SWL_MAX_LEN_CAP : max_len;
    wire [10:0] lim_len = cap_len + (tagged_q ? `SWL_VLAN_TAG_LEN : 11'h000);
    wire len_ok = (len_q >= `SWL_MIN_LEN) && (len_q <= lim_len);
    wire good = !err_q && len_ok;
    wire [3:0] need = buf_need(len_q);

    // Stage one: static entry, then multicast, then dynamic hit
    wire swl_pmask_t ing = port_mask(port_q);
    wire swl_pmask_t flood = `SWL_ALL_PORTS & ~ing;
    wire da_mc = da_q[`SWL_MCAST_BIT];
    wire swl_pmask_t dyn_set = da_hit_q ? port_mask(da_port_q) : flood;
    wire swl_pmask_t initial_egress_set = st_hit_q ? st_ports_q :
        (da_mc ? flood : dyn_set) & vlan_q;
    wire is_local = !st_hit_q && !da_mc && da_hit_q && (da_port_q == port_q);

    // Stage two: policy masks, then mirror copies, then ACL override
    wire swl_pmask_t policy_set = initial_egress_set & stp_q & vlan_q & auth_q & ~ing;
    wire swl_pmask_t mirror_set = (policy_set != 5'h00) ? (mir_q & ~ing) : 5'h00;
    wire swl_pmask_t final_egress_set = acl_hit_q ? acl_ports_q
                                                   : (policy_set | mirror_set);

    // Drop cases; a pool short of buffers also refuses the frame
    wire no_room = (buf_free_q < 10'(need));
    wire drop = !good || pause_q || is_local || no_room ||
        (final_egress_set == 5'h00);
    wire push_ready;
    wire in_resolve = (st_q == ST_RESOLVE);
    wire push_valid = in_resolve && !drop;
    wire go = in_resolve && (drop || push_ready);

    // Table writes happen as the frame leaves resolve, even if dropped
    wire learn = go && good && !sa_hit_q;
    wire migrate = go && good && sa_hit_q && (sa_port_q != port_q);
    wire refresh = go && sa_hit_q;
    wire wr_en = learn || refresh;
    wire [9:0] wr_idx = sa_hit_q ? sa_idx_q :
        (free_found_q ? free_idx_q : `SWL_LAST_IDX);
    wire swl_port_t wr_port = (learn || migrate) ? port_q : sa_port_q;

    assign frm_ready = (st_q == ST_IDLE);
    assign buf_free = buf_free_q;
    assign drop_pulse = drop_q;

    // Sequencer: scan starts only after the whole frame is in
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (frm_valid) begin
                    st_d = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (scan_last) begin
                    st_d = ST_RESOLVE;
                end
            end
            ST_RESOLVE: begin
                if (go) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    // Control state, scan bookkeeping and the aging clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            scan_idx_q <= '0;
            scan_cnt_q <= '0;
            tick_cnt_q <= '0;
            now_q <= '0;
            drop_q <= 1'b0;
        end else begin
            st_q <= st_d;
            scan_idx_q <= scan_idx_q + 10'h001;
            scan_cnt_q <= (st_q == ST_SCAN) ? scan_cnt_q + 10'h001 : 10'h000;
            tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
            now_q <= tick ? now_q + 3'h1 : now_q;
            drop_q <= go && drop;
        end
    end

    // Search results gathered over one full pass of the table
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sa_hit_q <= 1'b0;
            da_hit_q <= 1'b0;
            free_found_q <= 1'b0;
            sa_idx_q <= '0;
            free_idx_q <= '0;
            sa_port_q <= '0;
            da_port_q <= '0;
        end else if (frm_valid && frm_ready) begin
            sa_hit_q <= 1'b0;
            da_hit_q <= 1'b0;
            free_found_q <= 1'b0;
        end else if (st_q == ST_SCAN) begin
            if (sa_match) begin
                sa_hit_q <= 1'b1;
                sa_idx_q <= scan_idx_q;
                sa_port_q <= tbl_port_q[scan_idx_q];
            end
            if (da_match) begin
                da_hit_q <= 1'b1;
                da_port_q <= tbl_port_q[scan_idx_q];
            end
            if (!live && !free_found_q) begin
                free_found_q <= 1'b1;
                free_idx_q <= scan_idx_q;
            end
        end
    end

    // Frame descriptor captured at acceptance
    always_ff @(posedge core_clk) begin
        if (frm_valid && frm_ready) begin
            {port_q, sa_q, da_q, len_q} <= {frm_port, frm_sa, frm_da, frm_len};
            {err_q, pause_q, tagged_q} <= {frm_err, frm_pause, frm_tagged};
            {st_hit_q, st_ports_q, vlan_q} <= {static_hit, static_ports, vlan_member};
            {stp_q, auth_q, mir_q} <= {stp_fwd, auth_ok, mirror_ports};
            {acl_hit_q, acl_ports_q} <= {acl_hit, acl_ports};
        end
    end

    // Valid bits: a learn or refresh beats aging on the same slot
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `SWL_TBL_ENTRIES; i++) begin
                tbl_vld_q[i] <= 1'b0;
            end
        end else begin
            if (expire) begin
                tbl_vld_q[scan_idx_q] <= 1'b0;
            end
            if (wr_en) begin
                tbl_vld_q[wr_idx] <= 1'b1;
            end
        end
    end

    // Entry contents; a replaced last entry is simply overwritten
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            tbl_mac_q[wr_idx] <= sa_q;
            tbl_port_q[wr_idx] <= wr_port;
            tbl_stamp_q[wr_idx] <= now_q;
        end
    end

    // Pool accounting: claim on FIFO push, give back on release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_free_q <= `SWL_BUF_COUNT;
        end else begin
            buf_free_q <= buf_free_q - ((push_valid && push_ready) ? 10'(need) : 10'h000)
                + (buf_rel_valid ? 10'(buf_rel_cnt) : 10'h000);
        end
    end

    // Egress descriptors wait here; a full FIFO stalls resolve
    swl_fifo #(
        .WIDTH(`SWL_DESC_W),
        .DEPTH(`SWL_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data({final_egress_set, port_q, need}),
        .out_valid(fwd_valid),
        .out_ready(fwd_ready),
        .out_data({fwd_ports, fwd_src, fwd_nbuf})
    );

    // Checks beside the drop, override, table and pool logic
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_bad_frame_drop: assert property (push_valid |-> len_ok && !err_q)
        else $error("bad frame forwarded");
    chk_pause_consumed: assert property (in_resolve && pause_q |-> !push_valid)
        else $error("pause frame forwarded");
    chk_local_dropped: assert property (in_resolve && is_local && !acl_hit_q
        |-> !push_valid)
        else $error("local frame forwarded");
    chk_acl_override: assert property (push_valid && acl_hit_q
        |-> final_egress_set == acl_ports_q)
        else $error("acl result not applied");
    chk_ingress_excluded: assert property (push_valid && !acl_hit_q
        |-> (final_egress_set & ing) == 5'h00)
        else $error("frame sent back to ingress");
    chk_learn_entry: assert property (learn |=> tbl_vld_q[$past(wr_idx)] &&
        tbl_mac_q[$past(wr_idx)] == $past(sa_q) &&
        tbl_port_q[$past(wr_idx)] == $past(port_q))
        else $error("learned entry wrong");
    chk_full_last: assert property (learn && !free_found_q |-> wr_idx == `SWL_LAST_IDX)
        else $error("full table not replacing last entry");
    chk_migrate_port: assert property (migrate
        |=> tbl_port_q[$past(sa_idx_q)] == $past(port_q))
        else $error("migration not recorded");
    chk_stamp_fresh: assert property (refresh |=> tbl_stamp_q[$past(wr_idx)] == $past(now_q))
        else $error("stamp not refreshed");
    chk_store_first: assert property (frm_valid && frm_ready |=> !push_valid [*8])
        else $error("forward before scan");
    chk_pool_bound: assert property (buf_free_q <= `SWL_BUF_COUNT)
        else $error("buffer pool overflow");
    chk_aging_off: assert property (!aging_en && cur_vld |=> tbl_vld_q[$past(scan_idx_q)])
        else $error("entry aged while aging off");

    cov_learn: cover property (learn && free_found_q);
    cov_replace_last: cover property (learn && !free_found_q);
    cov_migrate: cover property (migrate);
    cov_acl: cover property (push_valid && acl_hit_q);
    cov_multicast: cover property (push_valid && da_mc && !st_hit_q);
endmodule

// ===== rtl/swl_fifo.sv
// Descriptor FIFO with valid/ready on both sides
`timescale 1ns/1ps
module swl_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import swl_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Honest flags straight from the occupancy count
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    // Storage needs no reset; only pointers and the count are control state
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ===== rtl/swl_params.svh
// Constants of the switch look-up and forwarding engine
// Overview of operation
// - Table holds 1k entries, all learnable.
// - Learn only absent source from good frames.
// - Entry keeps address, ingress port, time stamp.
// - Full table: drop last entry, then insert.
// - Known address on new port: rewrite port.
// - Every source hit refreshes the time stamp.
// - Scan always; expire entries after 225-300 s.
// - Global control bit 2 switches aging.
// - Stage one: VLAN, static, dynamic give initial set.
// - Stage two: policy masks give final set.
// - ACL result replaces the egress set; drop checks still apply.
// - Never forward error or bad-size frames.
// - Pause frames consumed, never forwarded.
// - Unicast destination on ingress port: local, drop.
// - Store-and-forward: whole frame before forwarding.
// - Shared pool of 512 buffers, 128 bytes.
// - Under 64 bytes illegal; max up to 1536.
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH
`define SWL_TBL_ENTRIES 1024
`define SWL_LAST_IDX 10'h3FF
`define SWL_ALL_PORTS 5'h1F
`define SWL_AGE_EN_BIT 2
`define SWL_AGE_TICK_S 75
`define SWL_AGE_LIMIT 3'h4
`define SWL_CLK_HZ 50000000
`define SWL_BUF_COUNT 10'h200
`define SWL_BUF_SHIFT 7
`define SWL_BUF_ROUND 11'h07F
`define SWL_MIN_LEN 11'h040
`define SWL_MAX_LEN_CAP 11'h600
`define SWL_VLAN_TAG_LEN 11'h004
`define SWL_MCAST_BIT 40
`define SWL_FIFO_DEPTH 16
`define SWL_DESC_W 12
`endif

// ===== rtl/swl_pkg.sv
// Types shared by the look-up engine and its descriptor FIFO
package swl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SCAN = 3'b010,
        ST_RESOLVE = 3'b100
    } swl_state_t;
    typedef logic [4:0] swl_pmask_t;
    typedef logic [47:0] swl_mac_t;
    typedef logic [2:0] swl_port_t;
endpackage
